// >>> hdl/serial_port_pkg.sv
package serial_port_pkg;

    // buffer and register indices; the byte address is four times the index
    localparam logic [15:0] BUF_FIRST_IDX = 16'h1f98;
    localparam logic [15:0] BUF_LAST_IDX = 16'h1f9f;
    localparam logic [15:0] CTRL_ONE_IDX = 16'h1fa0;
    localparam logic [15:0] CTRL_TWO_IDX = 16'h1fa1;
    localparam logic [15:0] STATUS_IDX = 16'h1fa2;
    localparam int BUF_WORDS = 8;

    // serial_control_one field positions
    localparam int C1_RUN = 8;
    localparam int C1_ABORT = 7;
    localparam int C1_MODE_LO = 5;
    localparam int C1_WIDTH8 = 4;
    localparam int C1_EXTCLK = 3;
    localparam int C1_RATE_LO = 0;
    // serial_control_two field positions
    localparam int C2_WAIT_LO = 3;
    localparam int C2_COUNT_LO = 0;
    // serial_status_reg field positions
    localparam int ST_ACTIVE = 0;
    localparam int ST_AUTOWAIT = 1;

    localparam logic [8:0] CTRL_ONE_RESET = 9'h000;
    localparam logic [4:0] CTRL_TWO_RESET = 5'h00;

    // internal serial clock: half period is RATE_BASE_HALF << rate, rates 0..5
    localparam logic [11:0] RATE_BASE_HALF = 12'h004;
    localparam logic [2:0] RATE_MAX = 3'h5;

    typedef enum logic [1:0] {
        MODE_TX = 2'h0,
        MODE_RX = 2'h1,
        MODE_TXRX = 2'h2
    } transfer_mode_select_t;

    typedef struct packed {
        logic serial_run_bit;
        logic serial_abort_bit;
        transfer_mode_select_t transfer_mode_select;
        logic width8;
        logic ext_clock;
        logic [2:0] rate;
    } serial_control_one_t;

    typedef struct packed {
        logic [1:0] wait_sel;
        logic [2:0] word_count;
    } serial_control_two_t;

    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic so_out;
    } serial_pins_t;

    // gray order along idle -> shift -> gap -> hold
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP = 2'b11,
        ST_HOLD = 2'b10
    } engine_state_t;

endpackage

// >>> hdl/clocked_serial_buffered_port.sv
// Behaviour
// RULE1 - eight byte buffer shared by send and receive, 64 bits per burst; the code moves n+1 words of 8 or 4 bits instead
// RULE2 - buffer sits on eight consecutive addresses; at most eight words per burst
// RULE3 - burst end after programmed words raises the serial interrupt
// RULE4 - internal clock wait field makes frame one, two, four or eight data times
// RULE5 - software keeps wait field zero outside 8-bit combined mode
// RULE6 - word count field n gives n+1 words from lowest entry upward
// RULE7 - 4-bit mode shifts low nibble; received upper nibble written zero
// RULE8 - transmit and receive start at lowest entry and go upward
// RULE9 - word count stays programmed after burst ends
// RULE10 - software writes control two only while not active
// RULE11 - both control registers write only; no read-modify-write
// RULE12 - software clears run and sets abort before changing mode or clock
// RULE13 - run cleared: active drops after current word, or at once on abort
// RULE14 - clock source bit picks internal or external serial clock
// RULE15 - internal clock: six rates, driven out, pin high at start
// RULE16 - internal clock halts when buffer service is not yet done
// RULE17 - external clock pulses exceed sixteen system clocks; pin is input
// RULE18 - transmit data changes on falling serial clock edge
// RULE19 - receive data sampled on rising serial clock edge
// RULE20 - words go least significant bit first in both widths
// RULE21 - software stops port before changing count, except during auto wait
// RULE22 - mode field picks send only, receive only or combined
// RULE23 - setting run starts a burst
// RULE24 - abort ends at once, mid word, and clears active flag
// RULE25 - active flag is one from burst start until end or abort; the code keeps it set across burst ends until run is cleared or abort is set
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_buffered_port
    import serial_port_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic sck_in,
    input wire logic si_in,
    output logic sck_out,
    output logic sck_oe,
    output logic so_out,
    // burst event
    output logic serial_burst_irq
);

    function automatic logic [15:0] word_index(input logic [15:0] addr);
        return {2'h0, addr[15:2]};
    endfunction

    function automatic logic buf_hit(input logic [15:0] addr);
        return word_index(addr) >= BUF_FIRST_IDX && word_index(addr) <= BUF_LAST_IDX
            && addr[1:0] == 2'h0;
    endfunction

    logic [7:0] data_buffer_area [BUF_WORDS];  // RULE1
    serial_control_one_t serial_control_one;
    serial_control_two_t serial_control_two;
    engine_state_t state;
    logic transfer_active_flag;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [2:0] word_idx;
    logic [2:0] bit_cnt;
    logic [11:0] div_cnt;
    logic [7:0] gap_cnt;
    logic sck_int;
    logic serviced;
    logic so_reg;
    logic irq;
    logic [1:0] sck_sync;
    logic [1:0] si_sync;
    logic sck_prev;

    // apb decode
    logic access;
    logic wr;
    logic rd;
    logic [2:0] buf_sel;
    logic buf_wr;
    logic buf_rd;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign buf_sel = paddr[4:2];
    assign buf_wr = wr && buf_hit(paddr);  // RULE2
    assign buf_rd = rd && buf_hit(paddr);
    assign pready = 1'b1;

    logic mapped;
    assign mapped = buf_hit(paddr) || paddr == {CTRL_ONE_IDX[13:0], 2'h0}
        || paddr == {CTRL_TWO_IDX[13:0], 2'h0} || paddr == {STATUS_IDX[13:0], 2'h0};
    assign pslverr = access && !mapped;

    // control registers never read back: software keeps its own copy
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd && buf_hit(paddr)) begin
            prdata = {24'h00_0000, data_buffer_area[buf_sel]};
        end else if (rd && paddr == {STATUS_IDX[13:0], 2'h0}) begin
            prdata[ST_ACTIVE] = transfer_active_flag;
            prdata[ST_AUTOWAIT] = state == ST_HOLD;
        end
    end  // RULE11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_one <= CTRL_ONE_RESET;
        end else if (wr && paddr == {CTRL_ONE_IDX[13:0], 2'h0}) begin
            serial_control_one <= pwdata[8:0];
        end
    end

    // the count is only ever changed by software, so it carries over bursts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_two <= CTRL_TWO_RESET;
        end else if (wr && paddr == {CTRL_TWO_IDX[13:0], 2'h0}) begin
            serial_control_two <= pwdata[4:0];  // RULE9
        end
    end

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_sync <= 2'b11;
            si_sync <= 2'b11;
            sck_prev <= 1'b1;
        end else begin
            sck_sync <= {sck_sync[0], sck_in};  // RULE17
            si_sync <= {si_sync[0], si_in};
            sck_prev <= sck_sync[1];
        end
    end

    logic internal;
    logic [11:0] half;
    logic tick;
    logic lead;
    logic trail;
    logic [2:0] last_bit;
    logic tx_on;
    logic rx_on;
    assign internal = !serial_control_one.ext_clock;  // RULE14
    assign half = RATE_BASE_HALF << ((serial_control_one.rate > RATE_MAX) ?
        RATE_MAX : serial_control_one.rate);  // RULE15
    assign tick = div_cnt == half - 12'h001;
    assign lead = internal ? (state == ST_SHIFT && tick && sck_int)
        : (state == ST_SHIFT && sck_prev && !sck_sync[1]);  // RULE18
    assign trail = internal ? (state == ST_SHIFT && tick && !sck_int)
        : (state == ST_SHIFT && !sck_prev && sck_sync[1]);  // RULE19
    assign last_bit = serial_control_one.width8 ? 3'h7 : 3'h3;  // RULE7
    assign tx_on = serial_control_one.transfer_mode_select != MODE_RX;  // RULE22
    assign rx_on = serial_control_one.transfer_mode_select != MODE_TX;

    logic start;
    logic abort;
    logic word_done;
    logic burst_done;
    logic service_evt;
    logic [7:0] rx_word;
    logic [7:0] gap_len;
    assign start = state == ST_IDLE && serial_control_one.serial_run_bit
        && !serial_control_one.serial_abort_bit;  // RULE23
    assign abort = serial_control_one.serial_abort_bit;
    assign word_done = trail && bit_cnt == last_bit;
    assign burst_done = word_done && word_idx == serial_control_two.word_count;  // RULE6
    // received bits enter at the top, so a nibble is moved from the high half of rx_sh to the low half
    assign rx_word = serial_control_one.width8 ? {si_sync[1], rx_sh[7:1]}
        : {4'h0, si_sync[1], rx_sh[7:5]};  // RULE7 RULE20
    // a write releases transmit, a read releases receive and combined mode
    assign service_evt = serial_control_one.transfer_mode_select == MODE_TX ? buf_wr : buf_rd;
    // extra gap ticks: (k-1) data times at two ticks per bit; last_bit[2] is set for 8-bit words
    always_comb begin
        case (serial_control_two.wait_sel)
            2'h1: gap_len = {3'h0, last_bit[2], !last_bit[2], 3'h0};
            2'h2: gap_len = {2'h0, last_bit[2], 1'b1, !last_bit[2], 3'h0};
            2'h3: gap_len = {1'b0, last_bit[2], 2'h3, !last_bit[2], 3'h0};
            default: gap_len = 8'h00;
        endcase
    end  // RULE4

    // engine sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else if (abort && state != ST_IDLE) begin
            state <= ST_IDLE;  // RULE24
        end else begin
            case (state)
                ST_IDLE: if (start) state <= ST_SHIFT;
                ST_SHIFT: begin
                    if (word_done && !serial_control_one.serial_run_bit) begin
                        state <= ST_IDLE;  // RULE13
                    end else if (burst_done) begin
                        if (internal && !(serviced || service_evt)) state <= ST_HOLD;  // RULE16
                    end else if (word_done && internal && gap_len != 8'h00) begin
                        state <= ST_GAP;
                    end
                end
                ST_GAP: if (tick && gap_cnt == gap_len - 8'h01) state <= ST_SHIFT;
                ST_HOLD: begin
                    if (!serial_control_one.serial_run_bit) state <= ST_IDLE;
                    else if (service_evt) state <= ST_SHIFT;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_active_flag <= 1'b0;
        end else if (start) begin
            transfer_active_flag <= 1'b1;  // RULE25
        end else if (state != ST_IDLE && (abort ||
                (word_done && !serial_control_one.serial_run_bit) ||
                (state == ST_HOLD && !serial_control_one.serial_run_bit))) begin
            transfer_active_flag <= 1'b0;  // RULE13 RULE24
        end
    end

    // buffer service seen since the last burst end; a new access wins over consumption
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serviced <= 1'b0;
        end else if (state == ST_IDLE) begin
            serviced <= 1'b0;
        end else if (service_evt && state != ST_HOLD) begin
            serviced <= 1'b1;
        end else if (burst_done) begin
            serviced <= 1'b0;
        end
    end

    // internal clock divider, run only while shifting or pacing a gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 12'h000;
        end else if (!(state == ST_SHIFT || state == ST_GAP) || tick || !internal) begin
            div_cnt <= 12'h000;
        end else begin
            div_cnt <= div_cnt + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 8'h00;
        end else if (state != ST_GAP) begin
            gap_cnt <= 8'h00;
        end else if (tick) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    // the pin idles high and stays high through gaps and waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_int <= 1'b1;
        end else if (state != ST_SHIFT || start) begin
            sck_int <= 1'b1;  // RULE15
        end else if (lead || trail) begin
            sck_int <= !sck_int;
        end
    end

    // shift, bit and word position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
            bit_cnt <= 3'h0;
            word_idx <= 3'h0;
            so_reg <= 1'b1;
        end else if (start || (state == ST_HOLD && service_evt)
                || (burst_done && state == ST_SHIFT && !(internal && !(serviced || service_evt)))) begin
            tx_sh <= data_buffer_area[0];  // RULE8
            bit_cnt <= 3'h0;
            word_idx <= 3'h0;
        end else if (word_done) begin
            tx_sh <= data_buffer_area[word_idx + 3'h1];
            bit_cnt <= 3'h0;
            word_idx <= word_idx + 3'h1;
        end else if (trail) begin
            tx_sh <= {1'b0, tx_sh[7:1]};  // RULE20
            rx_sh <= {si_sync[1], rx_sh[7:1]};
            bit_cnt <= bit_cnt + 3'h1;
        end else if (lead && tx_on) begin
            so_reg <= tx_sh[0];  // RULE18
        end else if (state == ST_IDLE) begin
            so_reg <= 1'b1;
        end
    end

    // received words land in the entry in use; software writes come second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < BUF_WORDS; i++) data_buffer_area[i] <= 8'h00;
        end else if (word_done && rx_on) begin
            data_buffer_area[word_idx] <= rx_word;  // RULE8
        end else if (buf_wr) begin
            data_buffer_area[buf_sel] <= pwdata[7:0];  // RULE1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= burst_done;  // RULE3
        end
    end

    serial_pins_t pins;
    assign pins = '{sck_out: sck_int, sck_oe: internal, so_out: so_reg};
    assign sck_out = pins.sck_out;
    assign sck_oe = pins.sck_oe;
    assign so_out = pins.so_out;
    assign serial_burst_irq = irq;

    AST_IRQ_AFTER_LAST: assert property (@(posedge pclk) disable iff (!presetn)
        burst_done |=> serial_burst_irq)  // RULE3
        else $error("burst end without irq");
    AST_ABORT_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        (abort && state != ST_IDLE) |=> !transfer_active_flag && state == ST_IDLE)  // RULE24
        else $error("abort did not stop transfer");
    AST_RUN_START: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> transfer_active_flag && state == ST_SHIFT && sck_out)  // RULE23
        else $error("run did not start burst");
    AST_STOP_AFTER_WORD: assert property (@(posedge pclk) disable iff (!presetn)
        (word_done && !serial_control_one.serial_run_bit) |=> !transfer_active_flag)  // RULE13
        else $error("active flag held after final word");
    AST_FLAG_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        transfer_active_flag == (state != ST_IDLE) || $past(start))  // RULE25
        else $error("active flag disagrees with engine");
    AST_NIBBLE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (word_done && rx_on && !serial_control_one.width8)
        |=> data_buffer_area[$past(word_idx)][7:4] == 4'h0)  // RULE7
        else $error("upper nibble not cleared");
    AST_COUNT_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && paddr == {CTRL_TWO_IDX[13:0], 2'h0}) |=> $stable(serial_control_two))  // RULE9
        else $error("word count changed by hardware");
    AST_SO_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        (internal && tx_on && lead) |=> !sck_out && so_out == $past(tx_sh[0]))  // RULE18
        else $error("transmit bit not placed on falling edge");
    AST_SAMPLE_ON_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        (internal && trail && !word_done) |=> sck_out && rx_sh[7] == $past(si_sync[1]))  // RULE19
        else $error("receive bit not taken on rising edge");
    AST_HOLD_CLOCK_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (internal && state == ST_HOLD) |-> sck_out)  // RULE16
        else $error("serial clock not halted high in wait");
    AST_IDX_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_SHIFT |-> word_idx <= serial_control_two.word_count)  // RULE6
        else $error("word index past programmed count");

    COV_BURST: cover property (@(posedge pclk) disable iff (!presetn) burst_done);
    COV_AUTOWAIT: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_HOLD ##1 state == ST_SHIFT);
    COV_GAP: cover property (@(posedge pclk) disable iff (!presetn) state == ST_GAP);
    COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn)
        abort && state == ST_SHIFT);

endmodule  // clocked_serial_buffered_port
`default_nettype wire

// >>> test/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    // clocks
    input wire logic pclk,
    input wire logic sck_line,
    // serial data
    input wire logic so,
    output logic si,
    // bench control
    input wire logic clear,
    input wire logic ext_go,
    input wire logic [6:0] ext_n,
    input wire logic [63:0] pattern,
    output logic ext_sck
);
    int cyc = 0;
    int idx = 0;
    int fall_at[$];
    logic rx_q[$];

    initial begin
        si = 1'b1;
        ext_sck = 1'b1;
    end

    always @(posedge pclk) cyc++;

    always @(posedge clear) begin
        rx_q.delete();
        fall_at.delete();
        idx = 0;
    end

    // new bit on the falling edge so it is steady when the device samples at the rise
    always @(negedge sck_line) begin
        fall_at.push_back(cyc);
        si = pattern[idx % 64];
        idx++;
    end

    always @(posedge sck_line) rx_q.push_back(so);

    // each level is held 250 ns, well past sixteen system clocks
    always @(posedge ext_go) begin
        repeat (ext_n) begin
            #250 ext_sck = 1'b0;
            #250 ext_sck = 1'b1;
        end
    end
endmodule // serial_peer
`default_nettype wire

// >>> test/tb_clocked_serial_buffered_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clocked_serial_buffered_port
    import serial_port_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, sck_out, sck_oe, so_out, serial_burst_irq, si, ext_sck;
    logic clear = 1'b0;
    logic ext_go = 1'b0;
    logic [6:0] ext_n = 7'h00;
    logic [63:0] pattern = 64'h0;
    logic [7:0] buf_exp [8];
    logic [31:0] r;
    logic e;
    logic sck_line;
    integer seed = 32'h4ce7;
    int fail_count = 0;
    int tests_run = 0;
    int irq_n = 0;
    int irq0;

    // in external mode the peer's ext_sck drives the line, and it rests high between frames
    assign sck_line = sck_oe ? sck_out : ext_sck;

    clocked_serial_buffered_port clocked_serial_buffered_port_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_in(sck_line), .si_in(si),
        .sck_out(sck_out), .sck_oe(sck_oe), .so_out(so_out),
        .serial_burst_irq(serial_burst_irq)
    );

    serial_peer serial_peer_inst (
        .pclk(pclk), .sck_line(sck_line), .so(so_out), .si(si), .clear(clear),
        .ext_go(ext_go), .ext_n(ext_n), .pattern(pattern), .ext_sck(ext_sck)
    );

    always #5 pclk = ~pclk;

    always @(posedge pclk) if (serial_burst_irq === 1'b1) irq_n++;

    task automatic close_out;
        $display("compared %0d, wrong %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_time(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            fail_count++;
            $display("wrong value at %0t: cycles %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask

    function automatic logic [15:0] ba(input logic [15:0] idx);
        return idx << 2;
    endfunction

    function automatic logic [31:0] c1(input logic run, input logic ab,
            input transfer_mode_select_t m, input logic w8, input logic ext,
            input logic [2:0] rate);
        serial_control_one_t s;
        s = '{run, ab, m, w8, ext, rate};
        return {23'h0, s};
    endfunction

    task automatic launch(input transfer_mode_select_t m, input logic w8, input logic ext,
                          input logic [2:0] rate);
        pattern <= {$random(seed), $random(seed)};
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        irq0 = irq_n;
        wr(ba(CTRL_ONE_IDX), c1(1'b1, 1'b0, m, w8, ext, rate));
    endtask

    task automatic burst(input transfer_mode_select_t m, input logic w8, input logic ext,
            input logic [2:0] rate, input logic [1:0] wt, input logic [2:0] cnt,
            input logic new_cnt);
        int nb;
        int n;
        logic [31:0] got;
        nb = w8 ? 8 : 4;
        wr(ba(CTRL_ONE_IDX), c1(1'b0, 1'b1, m, w8, ext, rate));
        if (new_cnt) wr(ba(CTRL_TWO_IDX), {27'h0, wt, cnt});
        for (int i = 0; i < 8; i++) begin
            buf_exp[i] = 8'($random(seed));
            wr(ba(BUF_FIRST_IDX + 16'(i)), {24'h0, buf_exp[i]});
        end
        launch(m, w8, ext, rate);
        if (ext) begin
            chk_val({31'h0, sck_oe}, 32'h0);
            ext_n <= 7'((cnt + 1) * nb);
            ext_go <= 1'b1;
        end
        n = 0;
        while (irq_n == irq0 && n < 40000) begin
            @(negedge pclk);
            n++;
        end
        if (irq_n == irq0) begin
            chk_time(0, 1);
            close_out();
        end
        ext_go <= 1'b0;
        if (!ext) begin
            apb(1'b0, ba(STATUS_IDX), 32'h0, r, e);
            chk_val(r, 32'h3);
        end
        wr(ba(CTRL_ONE_IDX), c1(1'b0, 1'b1, m, w8, ext, rate));
        chk_time(irq_n - irq0, 1);
        chk_time(serial_peer_inst.rx_q.size(), (cnt + 1) * nb);
        for (int w = 0; w <= cnt; w++) begin
            got = 32'h0;
            if (m != MODE_RX) begin
                for (int b = 0; b < nb; b++) got[b] = serial_peer_inst.rx_q[w * nb + b];
                chk_val(got, {24'h0, buf_exp[w] & (w8 ? 8'hff : 8'h0f)});
            end
            if (m != MODE_TX) begin
                apb(1'b0, ba(BUF_FIRST_IDX + 16'(w)), 32'h0, r, e);
                got = 32'(pattern >> (w * nb)) & (w8 ? 32'hff : 32'h0f);
                chk_val(r, got);
            end
        end
        if (!ext) begin
            n = serial_peer_inst.fall_at[1] - serial_peer_inst.fall_at[0];
            chk_time(n, 8 << rate);
            n = serial_peer_inst.fall_at[nb] - serial_peer_inst.fall_at[0];
            if (cnt > 0) chk_time(n, (nb * (8 << rate)) << wt);
        end
        $display("burst mode %0d width8 %0d ext %0d words %0d done", m, w8, ext, cnt + 1);
    endtask

    initial begin
        #900000;
        fail_count++;
        $display("wrong value at %0t: run did not finish", $time);
        close_out();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk_val({29'h0, sck_out, sck_oe, so_out}, 32'h7);
        apb(1'b0, ba(STATUS_IDX), 32'h0, r, e);
        chk_val(r, 32'h0);
        apb(1'b0, ba(CTRL_TWO_IDX), 32'h0, r, e);
        chk_val(r, 32'h0);
        apb(1'b0, ba(16'h1fa3), 32'h0, r, e);
        chk_val({e, r[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 8; i++) begin
            buf_exp[i] = 8'($random(seed));
            wr(ba(BUF_FIRST_IDX + 16'(i)), {24'h0, buf_exp[i]});
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ba(BUF_FIRST_IDX + 16'(i)), 32'h0, r, e);
            chk_val(r, {24'h0, buf_exp[i]});
        end
        $display("register map done");
        burst(MODE_TX, 1'b1, 1'b0, 3'h0, 2'h0, 3'h7, 1'b1);
        burst(MODE_TX, 1'b0, 1'b0, 3'h1, 2'h0, 3'h3, 1'b1);
        burst(MODE_RX, 1'b0, 1'b0, 3'h1, 2'h0, 3'h2, 1'b1);
        burst(MODE_RX, 1'b0, 1'b0, 3'h1, 2'h0, 3'h2, 1'b0);
        for (int i = 0; i < 6; i++) begin
            burst(MODE_TXRX, 1'b1, 1'b0, 3'(i), 2'(i % 4), 3'h1, 1'b1);
        end
        burst(MODE_RX, 1'b1, 1'b1, 3'h0, 2'h0, 3'h1, 1'b1);
        burst(MODE_TX, 1'b1, 1'b1, 3'h0, 2'h0, 3'h0, 1'b1);
        wr(ba(CTRL_ONE_IDX), c1(1'b0, 1'b1, MODE_TX, 1'b1, 1'b0, 3'h2));
        wr(ba(CTRL_TWO_IDX), 32'h0000_0007);
        launch(MODE_TX, 1'b1, 1'b0, 3'h2);
        repeat (100) @(posedge pclk);
        wr(ba(CTRL_ONE_IDX), c1(1'b0, 1'b1, MODE_TX, 1'b1, 1'b0, 3'h2));
        apb(1'b0, ba(STATUS_IDX), 32'h0, r, e);
        chk_val(r, 32'h0);
        chk_time(irq_n, irq0);
        $display("abort mid word done");
        launch(MODE_TX, 1'b1, 1'b0, 3'h0);
        repeat (100) @(posedge pclk);
        wr(ba(CTRL_ONE_IDX), c1(1'b0, 1'b0, MODE_TX, 1'b1, 1'b0, 3'h0));
        apb(1'b0, ba(STATUS_IDX), 32'h0, r, e);
        chk_val(r, 32'h1);
        for (int i = 0; i < 200 && r !== 32'h0; i++) apb(1'b0, ba(STATUS_IDX), 32'h0, r, e);
        chk_val(r, 32'h0);
        chk_time(serial_peer_inst.rx_q.size() % 8, 0);
        $display("run clear done");
        wr(ba(CTRL_ONE_IDX), c1(1'b0, 1'b1, MODE_TX, 1'b1, 1'b0, 3'h0));
        wr(ba(CTRL_TWO_IDX), 32'h0000_0000);
        launch(MODE_TX, 1'b1, 1'b0, 3'h0);
        for (int i = 0; i < 2000 && irq_n == irq0; i++) @(negedge pclk);
        chk_time(irq_n - irq0, 1);
        wr(ba(CTRL_TWO_IDX), 32'h0000_0001);
        irq0 = irq_n;
        wr(ba(BUF_FIRST_IDX), 32'h0000_005a);
        for (int i = 0; i < 2000 && irq_n == irq0; i++) @(negedge pclk);
        chk_time(irq_n - irq0, 1);
        chk_time(serial_peer_inst.rx_q.size(), 24);
        $display("count change in auto wait done");
        close_out();
    end
endmodule // tb_clocked_serial_buffered_port
`default_nettype wire
